// file: psmp_framer.sv
// message framer that feeds a stream transport toward a remote parser
`timescale 1ns/10ps
module psmp_framer (
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_msg_start,
   input  wire logic [31:0] i_msg_len,
   input  wire logic [15:0] i_vendor_id,
   input  wire logic [95:0] i_guid_prefix,
   input  wire logic        i_sub_valid,
   input  wire logic [7:0]  i_sub_kind,
   input  wire logic [7:0]  i_sub_flags,
   input  wire logic [15:0] i_sub_len,
   input  wire logic        i_sub_last,
   output logic             o_sub_ready,
   input  wire logic        i_pay_valid,
   input  wire logic [7:0]  i_pay_data,
   output logic             o_pay_ready,
   output logic             o_tx_valid,
   output logic [7:0]       o_tx_data,
   output logic             o_tx_last,
   input  wire logic        i_tx_ready,
   output logic             o_busy,
   output logic             o_done,
   output logic             o_err
);
   psmp_pkg::psmp_regs_t s_reg;
   psmp_pkg::psmp_regs_t s_next;
   logic                 free;
   logic                 sub_fire;
   logic [31:0]          sub_span;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   // header fields go out most significant byte first
   function automatic logic [7:0] hdr_byte(input logic [4:0] i, input logic [15:0] v,
                                           input logic [95:0] g);
      logic [7:0] b;
      b = 8'h00;
      if (i < psmp_pkg::OFF_VER)
         b = 8'(psmp_pkg::PROTO_ID >> {i[1:0] ^ 2'h3, 3'b000});
      else if (i == psmp_pkg::OFF_VER)
         b = psmp_pkg::VER_MAJOR;
      else if (i < psmp_pkg::OFF_VENDOR)
         b = psmp_pkg::VER_MINOR;
      else if (i < psmp_pkg::OFF_GUID)
         b = 8'(v >> {psmp_pkg::OFF_GUID - 5'h01 - i, 3'b000});
      else
         b = 8'(g >> {psmp_pkg::HDR_LEN - 5'h01 - i, 3'b000});
      return b;
   endfunction

   function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] i);
      return 8'(w >> {i ^ 2'h3, 3'b000});
   endfunction

   always_comb
   begin
      s_next   = s_reg;
      free     = !s_reg.tx_valid || i_tx_ready;
      sub_fire = i_sub_valid && s_reg.sub_ready;
      sub_span = {16'h0000, i_sub_len} + 32'(psmp_pkg::SUB_HDR_LEN);
      s_next.done = 1'b0;
      s_next.err  = 1'b0;
      if (i_tx_ready)
      begin
         s_next.tx_valid = 1'b0;
         s_next.tx_last  = 1'b0;
      end
      case (s_reg.st)
         psmp_pkg::ST_IDLE:
            if (i_msg_start)
            begin
               if (i_msg_len < 32'(psmp_pkg::HDR_LEN))
                  s_next.err = 1'b1;
               else
               begin
                  s_next.st     = psmp_pkg::ST_PREFIX;
                  s_next.idx    = 5'h00;
                  s_next.rem    = i_msg_len;
                  s_next.vendor = i_vendor_id;
                  s_next.guid   = i_guid_prefix;
               end
            end
         psmp_pkg::ST_PREFIX:
            if (free)
            begin
               // length travels ahead so the far end can find the boundary
               s_next.tx_valid = 1'b1;
               s_next.tx_data  = be_byte(s_reg.rem, s_reg.idx[1:0]);
               s_next.idx      = s_reg.idx + 5'h01;
               if (s_reg.idx == psmp_pkg::PFX_LEN - 5'h01)
               begin
                  s_next.st  = psmp_pkg::ST_HDR;
                  s_next.idx = 5'h00;
               end
            end
         psmp_pkg::ST_HDR:
            if (free)
            begin
               s_next.tx_valid = 1'b1;
               s_next.tx_data  = hdr_byte(s_reg.idx, s_reg.vendor, s_reg.guid);
               s_next.tx_last  = s_reg.rem == 32'h1;
               s_next.rem      = s_reg.rem - 32'h1;
               s_next.idx      = s_reg.idx + 5'h01;
               if (s_reg.idx == psmp_pkg::HDR_LEN - 5'h01)
                  s_next.st = psmp_pkg::ST_SUBWAIT;
            end
         psmp_pkg::ST_SUBWAIT:
            if (s_reg.rem == 32'h0)
            begin
               // completion waits for the last byte to leave the output slot
               if (free)
               begin
                  s_next.done = 1'b1;
                  s_next.st   = psmp_pkg::ST_IDLE;
               end
            end
            else if (sub_fire)
            begin
               s_next.kind  = i_sub_kind;
               s_next.flags = i_sub_flags;
               s_next.len   = i_sub_len;
               s_next.idx   = 5'h00;
               // refusing here truncates the frame: no last byte follows
               if (s_reg.rem < 32'(psmp_pkg::SUB_HDR_LEN))
                  s_next.err = 1'b1;
               else if (sub_span > s_reg.rem)
                  s_next.err = 1'b1;
               else if (i_sub_last && i_sub_len != 16'h0000 && sub_span != s_reg.rem)
                  s_next.err = 1'b1;
               else
               begin
                  s_next.st = psmp_pkg::ST_SUBHDR;
                  if (i_sub_last || i_sub_len == 16'h0000)
                     s_next.pay_rem = s_reg.rem - 32'(psmp_pkg::SUB_HDR_LEN);
                  else
                     s_next.pay_rem = {16'h0000, i_sub_len};
               end
               if (s_next.err)
                  s_next.st = psmp_pkg::ST_IDLE;
            end
         psmp_pkg::ST_SUBHDR:
            if (free)
            begin
               s_next.tx_valid = 1'b1;
               case (s_reg.idx[1:0])
                  2'h0:    s_next.tx_data = s_reg.kind;
                  2'h1:    s_next.tx_data = s_reg.flags;
                  2'h2:    s_next.tx_data = s_reg.flags[psmp_pkg::FLAG_E] ? s_reg.len[7:0] : s_reg.len[15:8];
                  default: s_next.tx_data = s_reg.flags[psmp_pkg::FLAG_E] ? s_reg.len[15:8] : s_reg.len[7:0];
               endcase
               s_next.tx_last = s_reg.rem == 32'h1;
               s_next.rem     = s_reg.rem - 32'h1;
               s_next.idx     = s_reg.idx + 5'h01;
               if (s_reg.idx == psmp_pkg::SUB_HDR_LEN - 5'h01)
                  s_next.st = (s_reg.pay_rem != 32'h0) ? psmp_pkg::ST_PAY : psmp_pkg::ST_SUBWAIT;
            end
         psmp_pkg::ST_PAY:
            if (i_pay_valid && s_reg.pay_ready)
            begin
               s_next.tx_valid = 1'b1;
               s_next.tx_data  = i_pay_data;
               s_next.tx_last  = s_reg.rem == 32'h1;
               s_next.rem      = s_reg.rem - 32'h1;
               s_next.pay_rem  = s_reg.pay_rem - 32'h1;
               if (s_reg.pay_rem == 32'h1)
                  s_next.st = psmp_pkg::ST_SUBWAIT;
            end
         default:
            s_next.st = psmp_pkg::ST_IDLE;
      endcase
      // ready from a flop costs one idle cycle per payload byte
      s_next.sub_ready = s_next.st == psmp_pkg::ST_SUBWAIT && s_next.rem != 32'h0;
      s_next.pay_ready = s_next.st == psmp_pkg::ST_PAY && !s_next.tx_valid;
      s_next.busy      = s_next.st != psmp_pkg::ST_IDLE;
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         s_reg <= psmp_pkg::RESET_REGS;
      else
         s_reg <= s_next;
   end

   assign o_sub_ready = s_reg.sub_ready;
   assign o_pay_ready = s_reg.pay_ready;
   assign o_tx_valid  = s_reg.tx_valid;
   assign o_tx_data   = s_reg.tx_data;
   assign o_tx_last   = s_reg.tx_last;
   assign o_busy      = s_reg.busy;
   assign o_done      = s_reg.done;
   assign o_err       = s_reg.err;

   a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
      else $error("output byte changed while stalled");

   a_start_prefix: assert property (!o_busy && i_msg_start && i_msg_len >= 32'h14
      |=> o_busy && s_reg.st == psmp_pkg::ST_PREFIX && s_reg.rem == $past(i_msg_len))
      else $error("accepted message did not start");

   a_short_msg: assert property (!o_busy && i_msg_start && i_msg_len < 32'h14 |=> o_err && !o_busy)
      else $error("short message not refused");

   // length prefix and fixed header fields, the first byte of each field checked as it is loaded
   a_prefix_msb: assert property (s_reg.st == psmp_pkg::ST_PREFIX && s_reg.idx == 5'h00 && free
      |=> o_tx_valid && o_tx_data == s_reg.rem[31:24])
      else $error("length prefix byte wrong");

   a_proto_byte: assert property (s_reg.st == psmp_pkg::ST_HDR && s_reg.idx == 5'h00 && free
      |=> o_tx_data == psmp_pkg::PROTO_ID[31:24])
      else $error("protocol constant wrong");

   a_version_major: assert property (s_reg.st == psmp_pkg::ST_HDR && s_reg.idx == 5'h04 && free
      |=> o_tx_data == psmp_pkg::VER_MAJOR)
      else $error("major version byte wrong");

   a_version_minor: assert property (s_reg.st == psmp_pkg::ST_HDR && s_reg.idx == 5'h05 && free
      |=> o_tx_data == psmp_pkg::VER_MINOR)
      else $error("minor version byte wrong");

   a_vendor_hi: assert property (s_reg.st == psmp_pkg::ST_HDR && s_reg.idx == 5'h06 && free
      |=> o_tx_data == s_reg.vendor[15:8])
      else $error("vendor byte wrong");

   a_guid_first: assert property (s_reg.st == psmp_pkg::ST_HDR && s_reg.idx == 5'h08 && free
      |=> o_tx_data == s_reg.guid[95:88])
      else $error("guid prefix byte wrong");

   // submessage header bytes follow the descriptor that was taken
   a_sub_taken: assert property (sub_fire
      |=> !o_sub_ready && (s_reg.st == psmp_pkg::ST_SUBHDR || o_err))
      else $error("descriptor not taken");

   a_kind_byte: assert property (s_reg.st == psmp_pkg::ST_SUBHDR && s_reg.idx == 5'h00 && free
      |=> o_tx_data == s_reg.kind)
      else $error("kind byte wrong");

   a_flags_byte: assert property (s_reg.st == psmp_pkg::ST_SUBHDR && s_reg.idx == 5'h01 && free
      |=> o_tx_data == s_reg.flags)
      else $error("flags byte wrong");

   a_len_endian: assert property (s_reg.st == psmp_pkg::ST_SUBHDR && s_reg.idx == 5'h02 && free
      |=> o_tx_data == (s_reg.flags[0] ? s_reg.len[7:0] : s_reg.len[15:8]))
      else $error("length byte order wrong");

   a_zero_len: assert property (sub_fire && i_sub_len == 16'h0000 && s_reg.rem >= 32'h4
      |=> s_reg.pay_rem == $past(s_reg.rem) - 32'h4)
      else $error("zero length does not reach message end");

   a_next_offset: assert property (sub_fire && !i_sub_last && i_sub_len != 16'h0000 && sub_span <= s_reg.rem
      |=> s_reg.pay_rem == {16'h0000, $past(i_sub_len)})
      else $error("payload count differs from length");

   a_last_mismatch: assert property (sub_fire && i_sub_last && i_sub_len != 16'h0000
      && s_reg.rem >= 32'h4 && sub_span < s_reg.rem |=> o_err && !o_busy)
      else $error("short last submessage not refused");

   a_overrun_err: assert property (sub_fire && s_reg.rem >= 32'h4 && sub_span > s_reg.rem
      |=> o_err && !o_busy)
      else $error("overrunning submessage not refused");

   a_short_tail: assert property (sub_fire && s_reg.rem < 32'h4 |=> o_err && !o_busy)
      else $error("short tail not refused");

   a_pay_pass: assert property (i_pay_valid && o_pay_ready
      |=> o_tx_valid && o_tx_data == $past(i_pay_data))
      else $error("payload byte not passed");

   a_last_end: assert property (o_tx_valid && o_tx_last |-> s_reg.rem == 32'h0)
      else $error("last flag off the message end");

   a_done_drained: assert property (o_done |-> !o_tx_valid && s_reg.rem == 32'h0)
      else $error("message done with a byte pending");

   c_msg_done: cover property (o_done);
   c_msg_err: cover property (o_err);
   c_little_sub: cover property (sub_fire && i_sub_flags[0]);
   c_zero_len: cover property (sub_fire && i_sub_len == 16'h0000 ##[1:40] o_tx_last);
endmodule

// file: psmp_pkg.sv
// constants and types for the publish-subscribe message framer
package psmp_pkg;
   localparam logic [4:0]  PFX_LEN     = 5'h04;
   localparam logic [4:0]  HDR_LEN     = 5'h14;
   localparam logic [4:0]  SUB_HDR_LEN = 5'h04;
   localparam logic [4:0]  OFF_VER     = 5'h04;
   localparam logic [4:0]  OFF_VENDOR  = 5'h06;
   localparam logic [4:0]  OFF_GUID    = 5'h08;
   localparam logic [31:0] PROTO_ID    = 32'h50534d50; // arbitrary marker value
   localparam logic [7:0]  VER_MAJOR   = 8'h02;
   localparam logic [7:0]  VER_MINOR   = 8'h04;
   localparam int          FLAG_E      = 0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PREFIX,
      ST_HDR,
      ST_SUBWAIT,
      ST_SUBHDR,
      ST_PAY
   } psmp_state_t;

   typedef struct packed {
      psmp_state_t st;
      logic [4:0]  idx;
      logic [31:0] rem;
      logic [31:0] pay_rem;
      logic [15:0] vendor;
      logic [95:0] guid;
      logic [7:0]  kind;
      logic [7:0]  flags;
      logic [15:0] len;
      logic        tx_valid;
      logic [7:0]  tx_data;
      logic        tx_last;
      logic        sub_ready;
      logic        pay_ready;
      logic        done;
      logic        err;
      logic        busy;
   } psmp_regs_t;

   localparam psmp_regs_t RESET_REGS = '0;
endpackage

// file: psmp_peer.sv
// far-side parser model: paces the byte stream and counts cleanly framed messages
`timescale 1ns/10ps
module psmp_peer (
   input  wire logic       i_core_clk,
   input  wire logic       i_rst_n,
   input  wire logic       i_slow,
   input  wire logic       i_err,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_data,
   input  wire logic       i_tx_last,
   output logic            o_tx_ready,
   output int              o_good
);
   int         pos, total, left, hp;
   logic [7:0] hb [0:2];
   logic [1:0] ph = 2'h0;

   // slow mode takes one byte in four, so the framer must hold its output
   always @(negedge i_core_clk)
   begin
      ph = ph + 2'h1;
      o_tx_ready = !i_slow || ph == 2'h0;
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n || i_err)
         {pos, total, left, hp} = '0;
      else if (i_tx_valid && o_tx_ready)
      begin
         if (pos < 4)
            total = (total << 8) | i_tx_data;
         else if (pos >= 24 && left > 0)
            left--;
         else if (pos >= 24 && hp < 3)
         begin
            hb[hp] = i_tx_data;
            hp++;
         end
         else if (pos >= 24)
         begin
            hp = 0;
            left = hb[1][psmp_pkg::FLAG_E] ? int'({i_tx_data, hb[2]}) : int'({hb[2], i_tx_data});
            if (left == 0)
               left = total + 3 - pos;
         end
         pos++;
         if (i_tx_last)
         begin
            if (pos == total + 4 && left == 0 && hp == 0)
               o_good++;
            {pos, total} = '0;
         end
      end
   end
endmodule

// file: testbench.sv
// self-checking bench for the message framer against a far-side parser model
`timescale 1ns/10ps
module testbench;
   logic        i_core_clk = 1'b0;
   logic        i_rst_n, i_msg_start, i_sub_valid, i_sub_last, i_pay_valid, slow, tx_ready;
   logic [31:0] i_msg_len;
   logic [15:0] i_vendor_id, i_sub_len;
   logic [95:0] i_guid_prefix;
   logic [7:0]  i_sub_kind, i_sub_flags, i_pay_data, o_tx_data;
   logic        o_sub_ready, o_pay_ready, o_tx_valid, o_tx_last, o_busy, o_done, o_err;
   logic [8:0]  exq [$];
   int          num_errors = 0, n_compared = 0, left, exp_good = 0, good;
   integer      seed = 32'h9916;

   always #5 i_core_clk = ~i_core_clk;

   psmp_framer dut (.i_core_clk, .i_rst_n, .i_msg_start, .i_msg_len, .i_vendor_id, .i_guid_prefix,
      .i_sub_valid, .i_sub_kind, .i_sub_flags, .i_sub_len, .i_sub_last, .o_sub_ready, .i_pay_valid,
      .i_pay_data, .o_pay_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready(tx_ready),
      .o_busy, .o_done, .o_err);
   psmp_peer peer (.i_core_clk, .i_rst_n, .i_slow(slow), .i_err(o_err), .i_tx_valid(o_tx_valid),
      .i_tx_data(o_tx_data), .i_tx_last(o_tx_last), .o_tx_ready(tx_ready), .o_good(good));

   task automatic end_of_test();
   begin
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   end
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
   begin
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   end
   endtask

   // sel 0: descriptor slot, 1: payload slot, 2: message finished
   // checked before waiting, so a one-cycle pulse already up is not missed
   task automatic wait_for(input int sel);
   begin
      for (int n = 0; n < 400; n++)
      begin
         if ((sel == 0) ? o_sub_ready : (sel == 1) ? o_pay_ready : (o_done | o_err))
            return;
         @(negedge i_core_clk);
      end
      num_errors++;
      $display("ERROR %0t: wait ran out", $time);
      end_of_test();
   end
   endtask

   task automatic push(input logic [7:0] b);
   begin
      exq.push_back({left == 1, b});
      left--;
   end
   endtask

   task automatic start_msg(input logic [31:0] len, input logic bad);
      logic [191:0] h;
   begin
      @(negedge i_core_clk);
      i_msg_len = len;
      i_vendor_id = 16'($random(seed));
      i_guid_prefix = {$random(seed), $random(seed), $random(seed)};
      i_msg_start = 1'b1;
      @(negedge i_core_clk);
      i_msg_start = 1'b0;
      chk(o_busy, !bad);
      left = len + 4;
      h = {len, psmp_pkg::PROTO_ID, psmp_pkg::VER_MAJOR, psmp_pkg::VER_MINOR, i_vendor_id, i_guid_prefix};
      for (int i = 0; i < 24 && !bad; i++)
         push(h[191 - 8 * i -: 8]);
   end
   endtask

   task automatic sub(input logic [7:0] kind, fl, input logic [15:0] len, input logic last, input int npay,
                      input logic bad);
   begin
      wait_for(0);
      if (!bad)
      begin
         push(kind);
         push(fl);
         push(fl[psmp_pkg::FLAG_E] ? len[7:0] : len[15:8]);
         push(fl[psmp_pkg::FLAG_E] ? len[15:8] : len[7:0]);
      end
      {i_sub_kind, i_sub_flags, i_sub_len, i_sub_last, i_sub_valid} = {kind, fl, len, last, 1'b1};
      @(negedge i_core_clk);
      i_sub_valid = 1'b0;
      for (int i = 0; i < npay; i++)
      begin
         wait_for(1);
         i_pay_data = 8'($random(seed));
         i_pay_valid = 1'b1;
         push(i_pay_data);
         @(negedge i_core_clk);
         i_pay_valid = 1'b0;
      end
   end
   endtask

   task automatic wait_end(input logic bad, input string name);
   begin
      wait_for(2);
      chk(o_err, bad);
      chk(o_done, !bad);
      chk(exq.size(), 0);
      exp_good += int'(!bad);
      @(negedge i_core_clk);
      chk(o_busy, 1'b0);
      $display("test %s finished", name);
   end
   endtask

   // scoreboard: every accepted byte must match the oldest expected byte
   always @(posedge i_core_clk)
      if (i_rst_n === 1'b1 && o_tx_valid === 1'b1 && tx_ready === 1'b1)
         chk({o_tx_last, o_tx_data}, exq.size() > 0 ? exq.pop_front() : 9'bx);
   initial
   begin
      {i_rst_n, i_msg_start, i_sub_valid, i_pay_valid, slow, i_sub_last} = 6'h00;
      {i_msg_len, i_vendor_id, i_guid_prefix, i_sub_kind, i_sub_flags, i_sub_len, i_pay_data} = '0;
      repeat (2) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_rst_n = 1'b1;
      slow = 1'b1;
      start_msg(32'h24, 1'b0);
      sub(8'h15, 8'h01, 16'h0003, 1'b0, 3, 1'b0);
      sub(8'h09, 8'h00, 16'h0000, 1'b0, 5, 1'b0);
      wait_end(1'b0, "two submessages");
      slow = 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         start_msg(32'h1a, 1'b0);
         sub(8'($random(seed)), 8'($random(seed)), 16'h0002, 1'b1, 2, 1'b0);
         wait_end(1'b0, "random kind");
      end
      start_msg(32'h13, 1'b1);
      wait_end(1'b1, "short length");
      start_msg(32'h16, 1'b0);
      sub(8'h01, 8'h00, 16'h0000, 1'b1, 0, 1'b1);
      wait_end(1'b1, "short tail");
      start_msg(32'h1e, 1'b0);
      sub(8'h15, 8'h00, 16'h0008, 1'b0, 0, 1'b1);
      wait_end(1'b1, "length overrun");
      start_msg(32'h1e, 1'b0);
      sub(8'h15, 8'h00, 16'h0002, 1'b1, 0, 1'b1);
      wait_end(1'b1, "last length mismatch");
      start_msg(32'h1e, 1'b0);
      sub(8'h07, 8'h00, 16'h0006, 1'b0, 6, 1'b0);
      wait_end(1'b0, "exact fill");
      chk(good, exp_good);
      end_of_test();
   end
endmodule
